// ---- common/drt_pkg.sv ----
// Shared constants and types of the dual reload timer.
package drt_pkg;

    // Register byte addresses on the internal I/O port.
    localparam logic [7:0] ADDR_CNT0_LO = 8'h0C; // Channel 0 count, low.
    localparam logic [7:0] ADDR_CNT0_HI = 8'h0D; // Channel 0 count, high.
    localparam logic [7:0] ADDR_RLD0_LO = 8'h0E; // Channel 0 reload, low.
    localparam logic [7:0] ADDR_RLD0_HI = 8'h0F; // Channel 0 reload, high.
    localparam logic [7:0] ADDR_CTRL    = 8'h10; // Control and status.
    localparam logic [7:0] ADDR_CNT1_LO = 8'h14; // Channel 1 count, low.
    localparam logic [7:0] ADDR_CNT1_HI = 8'h15; // Channel 1 count, high.
    localparam logic [7:0] ADDR_RLD1_LO = 8'h16; // Channel 1 reload, low.
    localparam logic [7:0] ADDR_RLD1_HI = 8'h17; // Channel 1 reload, high.

    // Field positions in the control and status register.
    localparam int unsigned POS_FLAG = 6; // Terminal flags, bits 7..6.
    localparam int unsigned POS_IE   = 4; // Interrupt enables, bits 5..4.
    localparam int unsigned POS_OC   = 2; // Output control, bits 3..2.
    localparam int unsigned POS_EN   = 0; // Count enables, bits 1..0.

    // Reset values.
    localparam logic [15:0] COUNT_RESET  = 16'hFFFF; // Count registers.
    localparam logic [15:0] RELOAD_RESET = 16'hFFFF; // Reload registers.
    localparam logic [1:0]  CTRL2_RESET  = 2'h0;     // Each 2-bit field.
    localparam logic [7:0]  HOLD_RESET   = 8'hFF;    // High-byte holder.
    localparam logic [7:0]  RDATA_RESET  = 8'h00;    // Read data port.

    // Timing: counters step once every this many system clocks.
    localparam int unsigned PRESCALE_DEFAULT = 20;

    // Modes of the shared pin, in the order of the output-control code.
    typedef enum logic [1:0] {
        WAVE_ADDR,
        WAVE_TOGGLE,
        WAVE_LOW,
        WAVE_HIGH
    } drt_wave_mode_e;

endpackage

// ---- design/drt_wave.sv ----
// Shared pin driver: address bit or channel 1 wave output.
`timescale 1ns/1ps

module drt_wave
(
    input  wire logic                    clk_sys_i,  // System clock.
    input  wire logic                    sys_rst_i,  // Async reset, high.
    input  wire drt_pkg::drt_wave_mode_e mode_i,     // Output control.
    input  wire logic                    term_i,     // Channel 1 hit zero.
    input  wire logic                    addr_bit_i, // CPU upper address.
    output logic                         pin_o,      // Shared pin level.
    output logic                         wave_sel_o  // Pin carries wave.
);
    import drt_pkg::*;

    logic wave_q;  // Timer output level.
    logic fresh_q; // No terminal count since the wave was selected.

    ////////////////////////////////////////////////////////////////////
    // Before the first terminal count the level simply follows the
    // programmed force value; afterwards it changes only on terminal
    // counts, so a mode change is applied at the next zero.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wave_q  <= 1'b0;
            fresh_q <= 1'b1;
        end else if (mode_i == WAVE_ADDR) begin
            // Returning to the address function re-arms the follow.
            fresh_q <= 1'b1;
        end else if (term_i) begin
            fresh_q <= 1'b0;
            case (mode_i)
                WAVE_TOGGLE: wave_q <= ~wave_q;
                WAVE_LOW:    wave_q <= 1'b0;
                WAVE_HIGH:   wave_q <= 1'b1;
                default:     wave_q <= wave_q;
            endcase
        end else if (fresh_q) begin
            // Toggle mode keeps its level until the first zero.
            case (mode_i)
                WAVE_LOW:  wave_q <= 1'b0;
                WAVE_HIGH: wave_q <= 1'b1;
                default:   wave_q <= wave_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin multiplexer, registered so the pin comes from a flip-flop.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_o      <= 1'b0;
            wave_sel_o <= 1'b0;
        end else begin
            pin_o      <= (mode_i == WAVE_ADDR) ? addr_bit_i : wave_q;
            wave_sel_o <= (mode_i != WAVE_ADDR);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks on the pin.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    a_pin_addr_mode: assert property (mode_i == WAVE_ADDR
        |=> pin_o == $past(addr_bit_i) && !wave_sel_o)
        else $error("Pin does not carry the address bit.");
    a_toggle_on_zero: assert property (
        term_i && mode_i == WAVE_TOGGLE |=> wave_q != $past(wave_q))
        else $error("Wave did not toggle on terminal count.");
    a_force_high_pin: assert property (
        (mode_i == WAVE_HIGH && fresh_q) [*2] |=> pin_o)
        else $error("Forced high mode does not drive the pin high.");

    c_toggle_seen: cover property (term_i && mode_i == WAVE_TOGGLE);
endmodule

// ---- design/drt_top.sv ----
// Dual 16-bit reload timer with byte registers and shared pin output.
`timescale 1ns/1ps

// Behaviour
// - Reload value per channel as two bytes.
// - Counter reaching zero loads reload value.
// - Decrement once per twenty clocks when enabled.
// - Terminal flag sets when counter reaches zero.
// - Flag clears after control read, count read.
// - Interrupt request when flag and enable set.
// - Counter holds while count enable is zero.
// - Output control selects address, toggle, low, high.
// - Reset clears control, counters all ones.
// - Low-byte read latches high byte for later.
// - Before first zero, pin follows programmed value.
module drt_top
#(
    parameter int unsigned PRESCALE_DIV = drt_pkg::PRESCALE_DEFAULT
)
(
    input  wire logic       clk_sys_i,  // System clock, 25 MHz.
    input  wire logic       sys_rst_i,  // Async reset, active high.
    input  wire logic [7:0] io_addr_i,  // I/O register address.
    input  wire logic       io_wr_i,    // One-cycle write strobe.
    input  wire logic       io_rd_i,    // One-cycle read strobe.
    input  wire logic [7:0] io_wdata_i, // Write data.
    input  wire logic       addr_bit_i, // CPU upper address bit.
    output logic      [7:0] io_rdata_o, // Read data, valid after strobe.
    output logic      [1:0] irq_o,      // Interrupt request per channel.
    output logic            upper_address_bit_o, // Shared pin level.
    output logic            wave_sel_o  // High while pin carries wave.
);
    import drt_pkg::*;

    localparam int unsigned PRE_W = $clog2(PRESCALE_DIV);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE_DIV - 1);
    // Tick spacing less one, for the prescaler check below.
    localparam int               TICK_GAP = int'(PRESCALE_DIV) - 1;

    // Refuse a divider that cannot produce a periodic tick.
    if (PRESCALE_DIV < 2) begin : g_bad_div
        $error("PRESCALE_DIV must be at least 2.");
    end

    ////////////////////////////////////////////////////////////////////
    // Address decoding used by both channels; the read port decodes the addresses itself.
    // One function per byte keeps both channel decoders identical, so a
    // new address cannot be wired into one channel only.
    function automatic logic [7:0] cnt_lo_addr(input int ch);
        return (ch == 1) ? ADDR_CNT1_LO : ADDR_CNT0_LO;
    endfunction

    function automatic logic [7:0] cnt_hi_addr(input int ch);
        return (ch == 1) ? ADDR_CNT1_HI : ADDR_CNT0_HI;
    endfunction

    function automatic logic [7:0] rld_lo_addr(input int ch);
        return (ch == 1) ? ADDR_RLD1_LO : ADDR_RLD0_LO;
    endfunction

    function automatic logic [7:0] rld_hi_addr(input int ch);
        return (ch == 1) ? ADDR_RLD1_HI : ADDR_RLD0_HI;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // State.
    logic [PRE_W-1:0] pre_q;          // Prescaler position.
    logic             tick;           // Last cycle of a prescaler period.
    logic [15:0]      count_q  [2];   // Down counters.
    logic [15:0]      reload_q [2];   // Reload values.
    logic [7:0]       hold_q   [2];   // High byte caught by low read.
    logic [1:0]       flag_q;         // Terminal flags.
    logic [1:0]       armed_q;        // Control read while flag was set.
    logic [1:0]       ie_q;           // Interrupt enables.
    logic [1:0]       oc_q;           // Output control code.
    logic [1:0]       en_q;           // Count enables.
    logic [1:0]       term;           // Counter steps to zero this cycle.
    logic             rd_ctrl;        // Control register read.
    logic             wr_ctrl;        // Control register write.

    assign tick    = (pre_q == PRE_LAST);
    assign rd_ctrl = io_rd_i && (io_addr_i == ADDR_CTRL);
    assign wr_ctrl = io_wr_i && (io_addr_i == ADDR_CTRL);

    ////////////////////////////////////////////////////////////////////
    // Prescaler: one tick every PRESCALE_DIV clocks, free running so
    // that the first step after an enable may come early by up to one
    // period; that is the cost of sharing one divider.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pre_q <= '0;
        end else if (tick) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + PRE_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control fields that software writes.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ie_q <= CTRL2_RESET;
            oc_q <= CTRL2_RESET;
            en_q <= CTRL2_RESET;
        end else if (wr_ctrl) begin
            // The flag bits are read only; written values are dropped.
            ie_q <= io_wdata_i[POS_IE +: 2];
            oc_q <= io_wdata_i[POS_OC +: 2];
            en_q <= io_wdata_i[POS_EN +: 2];
        end
    end

    // The flag bits take no part in a control write; only terminal
    // counts and the clear sequence move them.
    a_flags_readonly: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        wr_ctrl && term == 2'b00 |=> flag_q == $past(flag_q))
        else $error("Control write changed a terminal flag.");

    ////////////////////////////////////////////////////////////////////
    // The two channels.
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        logic wr_cnt_lo; // Count low byte write.
        logic wr_cnt_hi; // Count high byte write.
        logic rd_cnt_lo; // Count low byte read.
        logic rd_cnt_hi; // Count high byte read.
        logic wr_rld_lo; // Reload low byte write.
        logic wr_rld_hi; // Reload high byte write.

        assign wr_cnt_lo = io_wr_i && (io_addr_i == cnt_lo_addr(ch));
        assign wr_cnt_hi = io_wr_i && (io_addr_i == cnt_hi_addr(ch));
        assign rd_cnt_lo = io_rd_i && (io_addr_i == cnt_lo_addr(ch));
        assign rd_cnt_hi = io_rd_i && (io_addr_i == cnt_hi_addr(ch));
        assign wr_rld_lo = io_wr_i && (io_addr_i == rld_lo_addr(ch));
        assign wr_rld_hi = io_wr_i && (io_addr_i == rld_hi_addr(ch));

        // A step from one to zero is the terminal count.
        assign term[ch] = tick && en_q[ch] && (count_q[ch] == 16'h0001);

        // Down counter. Counting wins over a byte write: software must
        // stop the channel before writing, or the write may be lost.
        always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                count_q[ch] <= COUNT_RESET;
            end else if (term[ch]) begin
                count_q[ch] <= reload_q[ch];
            end else if (tick && en_q[ch]) begin
                count_q[ch] <= count_q[ch] - 16'h0001;
            end else if (wr_cnt_lo) begin
                count_q[ch][7:0] <= io_wdata_i;
            end else if (wr_cnt_hi) begin
                count_q[ch][15:8] <= io_wdata_i;
            end
        end

        // Reload value, written a byte at a time.
        always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                reload_q[ch] <= RELOAD_RESET;
            end else if (wr_rld_lo) begin
                reload_q[ch][7:0] <= io_wdata_i;
            end else if (wr_rld_hi) begin
                reload_q[ch][15:8] <= io_wdata_i;
            end
        end

        // High byte holder: a low read snapshots the high byte so the
        // pair stays coherent while the counter runs.
        always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                hold_q[ch] <= HOLD_RESET;
            end else if (rd_cnt_lo) begin
                hold_q[ch] <= count_q[ch][15:8];
            end
        end

        // Terminal flag with two-step clear; a new terminal count in
        // the clearing cycle wins, so no event is lost.
        always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                flag_q[ch]  <= 1'b0;
                armed_q[ch] <= 1'b0;
            end else begin
                if (term[ch]) begin
                    flag_q[ch] <= 1'b1;
                end else if (armed_q[ch] && (rd_cnt_lo || rd_cnt_hi)) begin
                    flag_q[ch] <= 1'b0;
                end
                // Only a control read that saw the flag arms the clear.
                if (rd_ctrl && flag_q[ch]) begin
                    armed_q[ch] <= 1'b1;
                end else if (rd_cnt_lo || rd_cnt_hi) begin
                    armed_q[ch] <= 1'b0;
                end
            end
        end

        // Interrupt request, one cycle behind the flag.
        always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                irq_o[ch] <= 1'b0;
            end else begin
                irq_o[ch] <= flag_q[ch] && ie_q[ch];
            end
        end

        ////////////////////////////////////////////////////////////////
        // Checks for this channel. The clear sequence and the holder
        // break first when the read decoding changes, so both are
        // checked directly.
        a_reload_at_zero: assert property (@(posedge clk_sys_i)
            disable iff (sys_rst_i)
            term[ch] |=> count_q[ch] == $past(reload_q[ch]))
            else $error("Counter not reloaded at zero.");
        a_step_down_one: assert property (@(posedge clk_sys_i)
            disable iff (sys_rst_i)
            tick && en_q[ch] && count_q[ch] > 16'h0001
            |=> count_q[ch] == $past(count_q[ch]) - 16'h0001)
            else $error("Counter did not step down by one.");
        a_tick_spacing: assert property (@(posedge clk_sys_i)
            disable iff (sys_rst_i)
            tick |=> !tick ##TICK_GAP tick)
            else $error("Prescaler ticks not evenly spaced.");
        a_flag_on_zero: assert property (@(posedge clk_sys_i)
            disable iff (sys_rst_i)
            term[ch] |=> flag_q[ch])
            else $error("Terminal flag not set at zero.");
        a_flag_needs_arm: assert property (@(posedge clk_sys_i)
            disable iff (sys_rst_i)
            flag_q[ch] && !armed_q[ch] |=> flag_q[ch])
            else $error("Flag cleared without a control read.");
        a_irq_gated: assert property (@(posedge clk_sys_i)
            disable iff (sys_rst_i)
            ##1 irq_o[ch] == $past(flag_q[ch] && ie_q[ch]))
            else $error("Interrupt request does not match flag.");
        a_hold_stopped: assert property (@(posedge clk_sys_i)
            disable iff (sys_rst_i)
            !en_q[ch] && !io_wr_i |=> $stable(count_q[ch]))
            else $error("Stopped counter changed.");
        a_high_latched: assert property (@(posedge clk_sys_i)
            disable iff (sys_rst_i)
            rd_cnt_lo ##2 rd_cnt_hi
            |=> io_rdata_o == $past(count_q[ch][15:8], 3))
            else $error("High read did not return latched byte.");
        a_flag_cleared: assert property (@(posedge clk_sys_i)
            disable iff (sys_rst_i)
            armed_q[ch] && (rd_cnt_lo || rd_cnt_hi) && !term[ch]
            |=> !flag_q[ch])
            else $error("Armed flag not cleared by a count read.");
        a_irq_blocked: assert property (@(posedge clk_sys_i)
            disable iff (sys_rst_i)
            !ie_q[ch] |=> !irq_o[ch])
            else $error("Interrupt raised while disabled.");
        a_write_stopped: assert property (@(posedge clk_sys_i)
            disable iff (sys_rst_i)
            !en_q[ch] && wr_cnt_lo |=> count_q[ch][7:0] == $past(io_wdata_i))
            else $error("Stopped counter lost a low byte write.");

        c_terminal: cover property (@(posedge clk_sys_i) term[ch]);
        c_flag_clear: cover property (@(posedge clk_sys_i)
            flag_q[ch] ##1 !flag_q[ch]);
    end

    ////////////////////////////////////////////////////////////////////
    // Read port: data is registered on the strobe and then holds.
    // Reads have side effects (holder load, flag clear), so the data is
    // taken once on the strobe and never decoded again afterwards.
    // Unmapped addresses read as zero.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            io_rdata_o <= RDATA_RESET;
        end else if (io_rd_i) begin
            case (io_addr_i)
                ADDR_CNT0_LO: io_rdata_o <= count_q[0][7:0];
                ADDR_CNT0_HI: io_rdata_o <= hold_q[0];
                ADDR_RLD0_LO: io_rdata_o <= reload_q[0][7:0];
                ADDR_RLD0_HI: io_rdata_o <= reload_q[0][15:8];
                ADDR_CTRL:    io_rdata_o <= {flag_q, ie_q, oc_q, en_q};
                ADDR_CNT1_LO: io_rdata_o <= count_q[1][7:0];
                ADDR_CNT1_HI: io_rdata_o <= hold_q[1];
                ADDR_RLD1_LO: io_rdata_o <= reload_q[1][7:0];
                ADDR_RLD1_HI: io_rdata_o <= reload_q[1][15:8];
                default:      io_rdata_o <= RDATA_RESET;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shared pin, driven by channel 1 terminal counts.
    drt_wave u_wave (
        .clk_sys_i  (clk_sys_i),
        .sys_rst_i  (sys_rst_i),
        .mode_i     (drt_wave_mode_e'(oc_q)),
        .term_i     (term[1]),
        .addr_bit_i (addr_bit_i),
        .pin_o      (upper_address_bit_o),
        .wave_sel_o (wave_sel_o)
    );

    c_irq_raised: cover property (@(posedge clk_sys_i) irq_o[1]);
endmodule

// ---- verif/drt_host.sv ----
// Host core model that reaches the timer registers on the I/O port.
`timescale 1ns/1ps

module drt_host
(
    input  wire logic       clk_sys_i,  // System clock.
    input  wire logic [7:0] io_rdata_i, // Read data from the timer.
    output logic      [7:0] io_addr_o,  // Register address.
    output logic            io_wr_o,    // Write strobe.
    output logic            io_rd_o,    // Read strobe.
    output logic      [7:0] io_wdata_o  // Write data.
);
    // Idle port at time zero.
    initial begin
        io_addr_o  = 8'hFF;
        io_wr_o    = 1'b0;
        io_rd_o    = 1'b0;
        io_wdata_o = 8'h00;
    end

    // One write, entered at a rising edge; a spare edge keeps strobes apart.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        io_addr_o  <= a;
        io_wdata_o <= d;
        io_wr_o    <= 1'b1;
        @(posedge clk_sys_i);
        io_wr_o    <= 1'b0;
        io_wdata_o <= ~d; // Released data must not keep the last value.
        @(posedge clk_sys_i);
    endtask

    // One read; data stands from the taking edge, sampled one edge later.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        io_addr_o <= a;
        io_rd_o   <= 1'b1;
        @(posedge clk_sys_i);
        io_rd_o   <= 1'b0;
        @(posedge clk_sys_i);
        d = io_rdata_i;
    endtask

    // A 16-bit value, low byte first so the high byte comes from the holder.
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        logic [7:0] l;
        logic [7:0] h;
        rd(a, l);
        rd(a + 8'h01, h);
        v = {h, l};
    endtask
endmodule

// ---- verif/tb_top.sv ----
// Self-checking testbench of the dual reload timer.
`timescale 1ns/1ps

module tb_top;
    import drt_pkg::*;

    localparam int unsigned DIV = 4; // Short prescale keeps the run brief.
    localparam logic [7:0] LO_A [4] = '{ADDR_CNT0_LO, ADDR_RLD0_LO,
                                        ADDR_CNT1_LO, ADDR_RLD1_LO};

    logic       clk_sys_i = 1'b0; // System clock.
    logic       sys_rst_i = 1'b1; // Reset, held at start.
    logic       addr_bit_i = 1'b1; // Address bit for the shared pin.
    logic [7:0] io_addr;          // Host port nets.
    logic       io_wr;
    logic       io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata_o;
    logic [1:0] irq_o;
    logic       upper_address_bit_o;
    logic       wave_sel_o;
    int         failures = 0;     // Mismatch counter.
    int         n_checks = 0;     // Comparison counter.
    int         cycles = 0;       // Hang guard.

    drt_top #(.PRESCALE_DIV(DIV)) uut (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd),
        .io_wdata_i(io_wdata), .addr_bit_i(addr_bit_i),
        .io_rdata_o(io_rdata_o), .irq_o(irq_o),
        .upper_address_bit_o(upper_address_bit_o),
        .wave_sel_o(wave_sel_o));

    drt_host u_host (
        .clk_sys_i(clk_sys_i), .io_rdata_i(io_rdata_o),
        .io_addr_o(io_addr), .io_wr_o(io_wr), .io_rd_o(io_rd),
        .io_wdata_o(io_wdata));

    // 25 MHz clock.
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare tasks and the closing report.
    task automatic chk8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk16(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("Checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Counts cycles until the pin level changes, seen at rising edges.
    task automatic wait_pin(output int n);
        logic p;
        p = upper_address_bit_o;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (upper_address_bit_o === p && n < 100);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic test_reset();
        logic [7:0]  d;
        logic [15:0] w;
        chk8("pin", {7'h0, addr_bit_i}, {7'h0, upper_address_bit_o});
        chk8("wave_sel", 8'h00, {7'h0, wave_sel_o});
        chk8("irq", 8'h00, {6'h0, irq_o});
        u_host.rd(ADDR_CTRL, d);
        chk8("ctrl", 8'h00, d);
        u_host.rd(8'h11, d);
        chk8("unmapped", 8'h00, d);
        for (int i = 0; i < 4; i++) begin
            u_host.rd16(LO_A[i], w);
            chk16("reset_word", i[0] ? RELOAD_RESET : COUNT_RESET, w);
        end
    endtask

    // Stopped counters hold bytes written high byte first; flags read-only.
    task automatic test_regs();
        logic [15:0] w;
        for (int i = 0; i < 4; i++) begin
            u_host.wr(LO_A[i] + 8'h01, ~LO_A[i]);
            u_host.wr(LO_A[i], LO_A[i]);
        end
        u_host.wr(ADDR_CTRL, 8'hC0);
        repeat (3 * DIV) @(posedge clk_sys_i);
        for (int i = 0; i < 4; i++) begin
            u_host.rd16(LO_A[i], w);
            chk16("byte_pair", {~LO_A[i], LO_A[i]}, w);
        end
        u_host.rd(ADDR_CTRL, w[7:0]);
        chk8("ctrl_ro", 8'h00, w[7:0]);
    endtask

    // Exactly ten steps in 10*DIV enabled clocks; high-byte holder.
    task automatic test_rate();
        logic [7:0]  d;
        logic [15:0] w;
        u_host.wr(ADDR_CNT1_LO, 8'h05);
        u_host.wr(ADDR_CNT1_HI, 8'h01);
        u_host.wr(ADDR_CTRL, 8'h02);
        repeat (10 * DIV - 2) @(posedge clk_sys_i);
        u_host.wr(ADDR_CTRL, 8'h00);
        u_host.rd16(ADDR_CNT1_LO, w);
        chk16("rate", 16'h00FB, w);
        u_host.rd(ADDR_CNT1_LO, d);
        u_host.wr(ADDR_CNT1_HI, 8'h44);
        u_host.rd(ADDR_CNT1_HI, d);
        chk8("holder", 8'h00, d);
        u_host.rd16(ADDR_CNT1_LO, w);
        chk16("holder_new", 16'h44FB, w);
    endtask

    // Terminal count, reload, flags, interrupt and the clear order.
    task automatic test_term();
        logic [7:0]  d;
        logic [15:0] w;
        int          i;
        for (i = 0; i < 4; i++) begin
            u_host.wr(LO_A[i], i[0] ? 8'h05 : 8'h03);
            u_host.wr(LO_A[i] + 8'h01, 8'h00);
        end
        u_host.wr(ADDR_CTRL, 8'h23);
        for (i = 0; i < 100 && irq_o[1] !== 1'b1; i++) begin
            @(posedge clk_sys_i);
        end
        chk8("irq_set", 8'h02, {6'h0, irq_o});
        u_host.wr(ADDR_CTRL, 8'h20);
        u_host.rd16(ADDR_CNT1_LO, w);
        chk16("reloaded", 16'h0005, w);
        u_host.rd(ADDR_CTRL, d);
        chk8("flags", 8'hE0, d);
        chk8("irq_held", 8'h02, {6'h0, irq_o});
        u_host.rd(ADDR_CNT1_HI, d);
        u_host.rd16(ADDR_CNT0_LO, w);
        chk16("reloaded0", 16'h0005, w);
        u_host.rd(ADDR_CTRL, d);
        chk8("flags_clr", 8'h20, d);
        chk8("irq_clr", 8'h00, {6'h0, irq_o});
    endtask

    // Pin modes: forced levels, toggle period and change at zero only.
    task automatic test_pin();
        int   n;
        logic p;
        u_host.wr(ADDR_CTRL, 8'h08);
        repeat (2) @(posedge clk_sys_i);
        chk8("force_low", 8'h02,
             {6'h0, wave_sel_o, upper_address_bit_o});
        u_host.wr(ADDR_CTRL, 8'h0C);
        repeat (2) @(posedge clk_sys_i);
        chk8("force_high", 8'h03,
             {6'h0, wave_sel_o, upper_address_bit_o});
        u_host.wr(ADDR_CTRL, 8'h04);
        u_host.wr(ADDR_CNT1_LO, 8'h02);
        u_host.wr(ADDR_RLD1_LO, 8'h02);
        chk8("toggle_keep", 8'h01, {7'h0, upper_address_bit_o});
        u_host.wr(ADDR_CTRL, 8'h06);
        wait_pin(n);
        for (int k = 0; k < 2; k++) begin
            wait_pin(n);
            chk8("toggle_gap", 8'(2 * DIV), 8'(n));
        end
        p = upper_address_bit_o;
        u_host.wr(ADDR_CTRL, p ? 8'h0A : 8'h0E);
        chk8("wait_zero", {7'h0, p}, {7'h0, upper_address_bit_o});
        wait_pin(n);
        chk8("forced_gap", 8'(2 * DIV - 2), 8'(n));
        repeat (2 * DIV + 2) @(posedge clk_sys_i);
        chk8("forced_lvl", {7'h0, ~p}, {7'h0, upper_address_bit_o});
        u_host.wr(ADDR_CTRL, 8'h00);
        addr_bit_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        chk8("addr_mode", 8'h00, {6'h0, wave_sel_o, upper_address_bit_o});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Hang guard: far above the few hundred cycles the run needs.
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end

    // Main sequence, with a second reset while everything is running.
    initial begin
        repeat (10) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        test_reset();
        test_regs();
        test_rate();
        test_term();
        test_pin();
        addr_bit_i <= 1'b1;
        u_host.wr(ADDR_CTRL, 8'h3F);
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        test_reset();
        complete_run();
    end
endmodule
